/* File: see_pkg.sv */
// Shared constants, types and decode functions of the serial EEPROM engine
package see_pkg;

  // Array geometry
  localparam int unsigned ADDR_W     = 9;
  localparam int unsigned MEM_DEPTH  = 512;
  localparam int unsigned PAGE_BYTES = 16;
  localparam int unsigned PAGE_W     = 4;

  // Opcodes, MSB first on the wire
  localparam logic [7:0] WRITE_ENABLE_CMD  = 8'h06;
  localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] READ_STATUS_CMD   = 8'h05;
  localparam logic [7:0] WRITE_STATUS_CMD  = 8'h01;
  localparam logic [7:0] READ_ARRAY_CMD    = 8'h03;
  localparam logic [7:0] WRITE_ARRAY_CMD   = 8'h02;
  localparam logic [7:0] ARRAY_OP_MASK     = 8'hF7;
  localparam int unsigned UPPER_HALF_ADDR_BIT = 3;

  // Status byte layout
  localparam int unsigned ST_BUSY_BIT  = 0;
  localparam int unsigned ST_LATCH_BIT = 1;
  localparam int unsigned ST_BL_LSB  = 2;
  localparam int unsigned ST_WD_LSB  = 4;
  localparam logic [7:0]  STATUS_RESET = 8'h30;
  localparam logic [3:0]  NV_RESET     = 4'hC;

  // Self-timed write cycle, longest time rounded down
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned T_WC_MS       = 10;
  localparam int unsigned T_WC_NS       = T_WC_MS * 1000000;
  localparam int unsigned WC_CYCLES_DEF = T_WC_NS / CLK_PERIOD_NS;

  // Position inside a frame
  typedef enum logic [1:0] {PH_OP, PH_ADDR, PH_DATA} see_phase_t;

  function automatic logic is_read_op(input logic [7:0] op);
    return (op & ARRAY_OP_MASK) == READ_ARRAY_CMD;
  endfunction

  function automatic logic is_write_op(input logic [7:0] op);
    return (op & ARRAY_OP_MASK) == WRITE_ARRAY_CMD;
  endfunction

endpackage

/* File: see_sync.sv */
// Two-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
module see_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  import see_pkg::*;

  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1) begin : g_bad_width
    $error("see_sync needs WIDTH of at least one");
  end

  // First stage feeds the second stage only
  always_ff @(posedge clk) begin
    meta_q <= d;
    q      <= meta_q;
  end

endmodule

/* File: see_wr_timer.sv */
// Self-timed nonvolatile write cycle counter
`timescale 1ns/1ps
module see_wr_timer #(
  parameter int unsigned CYCLES = see_pkg::WC_CYCLES_DEF
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  import see_pkg::*;

  localparam int unsigned CNT_W = $clog2(CYCLES + 1);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             busy_q;
  logic             busy_d;

  if (CYCLES < 1) begin : g_bad_cycles
    $error("see_wr_timer needs CYCLES of at least one");
  end

  // Load on start, count down while busy; a start while busy is dropped
  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done   = busy_q && (cnt_q == CNT_W'(1));
    if (start && !busy_q) begin
      cnt_d  = CNT_W'(CYCLES);
      busy_d = 1'b1;
    end else if (busy_q) begin
      cnt_d = cnt_q - CNT_W'(1);
      if (cnt_q == CNT_W'(1)) begin
        busy_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
    end
  end

  assign busy = busy_q;

  timer_start_a: assert property (@(posedge clk) disable iff (rst)
    start && !busy_q |=> busy_q && cnt_q == CNT_W'(CYCLES))
    else $error("write cycle did not start on request");

  timer_end_a: assert property (@(posedge clk) disable iff (rst)
    done |=> !busy_q)
    else $error("busy outlived the end of the write cycle");

endmodule

/* File: see_cmd_engine.sv */
// Command engine of a 512-byte serial EEPROM behind a four-wire serial link
//
// Function
// - Status opcode streams status byte on output
// - Status reads answered even while writing
// - Status write without prior deselect ignored
// - Writes need latch and protect pin high
// - Protect pin low refuses any write start
// - Read: opcode bit 3 plus address byte
// - Read address increments, wraps to zero
// - Deselect ends a read
// - Write: opcode, address, data after enable
// - Array write without prior deselect ignored
// - One to sixteen bytes within one page
// - Page address wraps, later bytes overwrite
// - Commit only if deselect after bit 0
// - Busy flag set during write cycle
// - After power-up wait for select fall; a select already low at reset release is taken as the fall
// - Power-up: output off, latch, flag cleared
// - Fixed opcode encodings for six commands
// - MSB first, sample rising, drive falling
// - Status layout, top bits zero, default 30H
// - Latch clears after write or protect low
`timescale 1ns/1ps
module see_cmd_engine #(
  parameter int unsigned WC_CYCLES = see_pkg::WC_CYCLES_DEF
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       si,
  output logic            so_o,
  output logic            so_oe,
  input  wire logic       wp_n,
  output logic [7:0]      status_byte
);
  import see_pkg::*;

  if (WC_CYCLES < 1) begin : g_bad_wc
    $error("WC_CYCLES must be at least one");
  end

  // Link side state, clocked by sck
  logic                  frame_rst;
  logic                  act_q;
  logic [2:0]            bit_q, bit_d, bit_c;
  see_phase_t            ph_q, ph_d, ph_c;
  logic [6:0]            sh_q, sh_d;
  logic [7:0]            op_q, op_d;
  logic [ADDR_W-1:0]     ptr_q, ptr_d;
  logic                  got_q, got_d;
  logic [7:0]            wsr_q, wsr_d;
  logic [PAGE_BYTES-1:0] mask_q, mask_d;
  logic [7:0]            byte_in;
  logic                  pb_we;
  logic [7:0]            pbuf_q [PAGE_BYTES];
  logic [7:0]            st_sck;
  logic [7:0]            out_q, out_d;
  logic                  oe_q, oe_d;
  logic                  load_c;

  // System side state, clocked by clk_sys
  logic                  cs_s;
  logic                  wp_s;
  logic                  cs_prev_q;
  logic                  armed_q, armed_d;
  logic                  wel_q, wel_d;
  logic [3:0]            nv_q, nv_d;
  logic                  rise_c;
  logic                  take_c;
  logic                  clean_c;
  logic                  wr_ok_c;
  logic                  start_c;
  logic                  page_we;
  logic                  busy;
  logic                  done;
  logic [7:0]            mem_q [MEM_DEPTH];

  // Protected range decode from the two top address bits
  function automatic logic locked(input logic [1:0] bl,
                                  input logic [1:0] hi);
    unique case (bl)
      2'b00: return 1'b0;
      2'b01: return hi == 2'b11;
      2'b10: return hi[1];
      2'b11: return 1'b1;
    endcase
  endfunction

  // Deselect resets the frame marker and the output driver at once
  assign frame_rst = cs_n | rst;
  assign byte_in   = {sh_q, si};

  // Frame marker: the first rising edge after select starts a fresh frame
  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      act_q <= 1'b0;
    end else begin
      act_q <= 1'b1;
    end
  end

  // Byte assembly and decode, MSB first on rising edges
  always_comb begin
    bit_c  = act_q ? bit_q : 3'h0;
    ph_c   = act_q ? ph_q : PH_OP;
    bit_d  = bit_c + 3'h1;
    sh_d   = {sh_q[5:0], si};
    ph_d   = ph_c;
    op_d   = op_q;
    ptr_d  = ptr_q;
    wsr_d  = wsr_q;
    got_d  = act_q & got_q;
    mask_d = act_q ? mask_q : '0;
    pb_we  = 1'b0;
    if (bit_c == 3'h7) begin
      unique case (ph_c)
        PH_OP: begin
          op_d = byte_in;
          if (is_read_op(byte_in) || is_write_op(byte_in)) begin
            ph_d = PH_ADDR;
          end else begin
            ph_d = PH_DATA;
          end
        end
        PH_ADDR: begin
          ptr_d = {op_q[UPPER_HALF_ADDR_BIT], byte_in};
          ph_d  = PH_DATA;
        end
        PH_DATA: begin
          got_d = 1'b1;
          wsr_d = byte_in;
          if (is_write_op(op_q)) begin
            pb_we                = 1'b1;
            mask_d[ptr_q[3:0]]   = 1'b1;
            ptr_d[PAGE_W-1:0]    = ptr_q[PAGE_W-1:0] + 4'h1;
          end else begin
            ptr_d = ptr_q + 9'h001;
          end
        end
        default: ph_d = PH_OP;
      endcase
    end
  end

  // Frame summary stays put after deselect so the system side can read it
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      bit_q  <= 3'h0;
      ph_q   <= PH_OP;
      sh_q   <= 7'h00;
      op_q   <= 8'h00;
      ptr_q  <= 9'h000;
      got_q  <= 1'b0;
      wsr_q  <= 8'h00;
      mask_q <= '0;
    end else begin
      bit_q  <= bit_d;
      ph_q   <= ph_d;
      sh_q   <= sh_d;
      op_q   <= op_d;
      ptr_q  <= ptr_d;
      got_q  <= got_d;
      wsr_q  <= wsr_d;
      mask_q <= mask_d;
    end
  end

  // Page buffer, later bytes of a wrapped page replace earlier ones
  always_ff @(posedge sck) begin
    if (pb_we) begin
      pbuf_q[ptr_q[PAGE_W-1:0]] <= byte_in;
    end
  end

  // Status seen from the link side; eight opcode edges flush the sync
  see_sync #(
    .WIDTH (8)
  ) u_st_sync (
    .clk (sck),
    .d   (status_byte),
    .q   (st_sck)
  );

  // Output shifter; the array is quiet while read, since reads are
  // refused during a write cycle and commits happen between frames
  always_comb begin
    load_c = act_q && (bit_q == 3'h0) && (ph_q == PH_DATA);
    out_d  = {out_q[6:0], 1'b0};
    oe_d   = oe_q;
    if (load_c && op_q == READ_STATUS_CMD) begin
      out_d = st_sck;
      oe_d  = 1'b1;
    end else if (load_c && is_read_op(op_q)
                 && (oe_q || !st_sck[ST_BUSY_BIT])) begin
      out_d = mem_q[ptr_q];
      oe_d  = 1'b1;
    end
  end

  // Drive on falling edges; deselect floats the pin at once
  always_ff @(negedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      out_q <= 8'h00;
      oe_q  <= 1'b0;
    end else begin
      out_q <= out_d;
      oe_q  <= oe_d;
    end
  end

  assign so_o  = out_q[7];
  assign so_oe = oe_q;

  // Pins from the host cross into the system clock
  see_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk (clk_sys),
    .d   ({cs_n, wp_n}),
    .q   ({cs_s, wp_s})
  );

  see_wr_timer #(
    .CYCLES (WC_CYCLES)
  ) u_timer (
    .clk   (clk_sys),
    .rst   (rst),
    .start (start_c),
    .busy  (busy),
    .done  (done)
  );

  // Command commit at deselect; summary is stable since sck is idle
  always_comb begin
    rise_c  = cs_s & ~cs_prev_q;
    take_c  = rise_c & armed_q & ~busy;
    clean_c = (bit_q == 3'h0) && (ph_q == PH_DATA);
    wr_ok_c = wel_q & wp_s;
    armed_d = armed_q;
    wel_d   = wel_q;
    nv_d    = nv_q;
    start_c = 1'b0;
    page_we = 1'b0;
    if (!cs_s && cs_prev_q) begin
      armed_d = 1'b1;
    end else if (rise_c) begin
      armed_d = 1'b0;
    end
    if (take_c && clean_c) begin
      if (op_q == WRITE_ENABLE_CMD && !got_q) begin
        wel_d = 1'b1;
      end else if (op_q == WRITE_DISABLE_CMD && !got_q) begin
        wel_d = 1'b0;
      end else if (op_q == WRITE_STATUS_CMD && got_q && wr_ok_c) begin
        nv_d    = wsr_q[5:2];
        start_c = 1'b1;
      end else if (is_write_op(op_q) && got_q && wr_ok_c
                   && !locked(nv_q[1:0], ptr_q[8:7])) begin
        page_we = 1'b1;
        start_c = 1'b1;
      end
    end
    if (done || !wp_s) begin
      wel_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cs_prev_q <= 1'b1;
      armed_q   <= 1'b0;
      wel_q     <= 1'b0;
      nv_q      <= NV_RESET;
    end else begin
      cs_prev_q <= cs_s;
      armed_q   <= armed_d;
      wel_q     <= wel_d;
      nv_q      <= nv_d;
    end
  end

  // Masked page copy into the array in one cycle
  always_ff @(posedge clk_sys) begin
    if (page_we) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (mask_q[i]) begin
          mem_q[{ptr_q[8:4], 4'(i)}] <= pbuf_q[i];
        end
      end
    end
  end

  // Top bits read as zero
  assign status_byte = {2'b00, nv_q, wel_q, busy};

  wip_start_a: assert property (@(posedge clk_sys) disable iff (rst)
    start_c |=> status_byte[ST_BUSY_BIT] ##1 status_byte[ST_BUSY_BIT])
    else $error("busy flag missing after write start");
  wp_block_a: assert property (@(posedge clk_sys) disable iff (rst)
    !wp_s |-> !start_c)
    else $error("write started with protect pin low");
  wel_need_a: assert property (@(posedge clk_sys) disable iff (rst)
    start_c |-> wel_q && clean_c && got_q)
    else $error("write started without enable latch");
  wel_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    (done || !wp_s) |=> !wel_q)
    else $error("enable latch survived write end or protect");
  busy_ignore_a: assert property (@(posedge clk_sys) disable iff (rst)
    busy |-> !page_we && nv_d == nv_q && (wel_d == wel_q || done || !wp_s))
    else $error("command taken while write cycle runs");
  abort_cmd_a: assert property (@(posedge clk_sys) disable iff (rst)
    rise_c && !clean_c |-> !start_c && !page_we)
    else $error("write committed on a partial byte");
  power_up_a: assert property (@(posedge clk_sys)
    $past(rst) && !rst |-> status_byte == STATUS_RESET && !armed_q)
    else $error("wrong state after reset release");
  read_wrap_a: assert property (@(posedge sck) disable iff (rst)
    act_q && ph_q == PH_DATA && bit_q == 3'h7 && is_read_op(op_q)
    && ptr_q == 9'h1FF |=> ptr_q == 9'h000)
    else $error("read address failed to wrap to zero");
  page_wrap_a: assert property (@(posedge sck) disable iff (rst)
    act_q && ph_q == PH_DATA && bit_q == 3'h7 && is_write_op(op_q)
    && ptr_q[3:0] == 4'hF |=> ptr_q[3:0] == 4'h0
    && ptr_q[8:4] == $past(ptr_q[8:4]))
    else $error("page address left its page");

endmodule

/* File: see_host_model.sv */
// Serial link host model: frames bytes on the link and collects replies
`timescale 1ns/1ps
module see_host_model (
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  input  wire logic so_o,
  input  wire logic so_oe
);
  localparam time HALF = 40;
  logic [7:0] rx_q [$];

  // Idle: deselected, clock parked low between frames
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // One frame, MSB first; tail adds loose ones that break the last byte
  task automatic frame(input logic [7:0] tx [$], input int tail);
    logic [7:0] b;
    logic [7:0] sh;
    int         n;
    // Start off the system clock edge so no pin moves on it
    #3;
    rx_q.delete();
    n = tx.size() * 8 + tail;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      b  = (i / 8 < tx.size()) ? tx[i / 8] : 8'hFF;
      si = b[7 - i % 8];
      #HALF sck = 1'b1;
      // Undriven output is taken as unknown, so it never matches
      sh = {sh[6:0], so_oe ? so_o : 1'bx};
      if (i % 8 == 7)
        rx_q.push_back(sh);
      #HALF sck = 1'b0;
    end
    #HALF cs_n = 1'b1;
    si = ~si;
    // Deselect gap long enough for the commit to cross domains
    #100;
  endtask
endmodule

/* File: see_cmd_engine_bench.sv */
// Self-checking bench of the serial EEPROM command engine
`timescale 1ns/1ps
module see_cmd_engine_bench;
  import see_pkg::*;
  localparam int unsigned WC = 400;
  logic       clk_sys;
  logic       rst;
  logic       wp_n;
  logic       sck;
  logic       cs_n;
  logic       si;
  logic       so_o;
  logic       so_oe;
  logic [7:0] status_byte;
  logic [7:0] q [$];
  logic [7:0] d [$];
  int         fail_count;
  int         n_tests;

  // Short write cycle keeps polling loops brief
  see_cmd_engine #(.WC_CYCLES(WC)) dut (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .sck         (sck),
    .cs_n        (cs_n),
    .si          (si),
    .so_o        (so_o),
    .so_oe       (so_oe),
    .wp_n        (wp_n),
    .status_byte (status_byte)
  );

  see_host_model host (
    .sck   (sck),
    .cs_n  (cs_n),
    .si    (si),
    .so_o  (so_o),
    .so_oe (so_oe)
  );

  // System clock, 5 ns period
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic check(input string w, input logic [7:0] s,
                       input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", w, e, s);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] op(input logic [7:0] base, input logic hi);
    return base | (8'(hi) << UPPER_HALF_ADDR_BIT);
  endfunction

  // Frame, then give the commit time to reach the status flops
  task automatic send(input int tail);
    host.frame(q, tail);
    repeat (10) @(posedge clk_sys);
  endtask

  // Bounded poll of the busy flag
  task automatic wait_idle();
    for (int i = 0; i < 4 * WC && status_byte[ST_BUSY_BIT] !== 1'b0; i++)
      @(posedge clk_sys);
  endtask

  task automatic wire_status(input logic [7:0] e);
    q = '{READ_STATUS_CMD, 8'h00};
    send(0);
    check("so status", host.rx_q[1], e);
  endtask

  // Enable frame, deselect, then the write frame itself
  task automatic wr_array(input logic [8:0] a, input int tail);
    q = '{WRITE_ENABLE_CMD};
    send(0);
    q = '{op(WRITE_ARRAY_CMD, a[8]), a[7:0]};
    foreach (d[i]) q.push_back(d[i]);
    host.frame(q, tail);
  endtask

  task automatic rd_check(input logic [8:0] a);
    q = '{op(READ_ARRAY_CMD, a[8]), a[7:0]};
    foreach (d[i]) q.push_back(8'h00);
    send(0);
    foreach (d[i]) check("rd data", host.rx_q[i + 2], d[i]);
  endtask

  task automatic t_reset();
    check("rst status", status_byte, STATUS_RESET);
    check("rst so_oe", {7'h0, so_oe}, 8'h00);
    wire_status(8'h30);
  endtask

  task automatic t_latch();
    q = '{WRITE_ENABLE_CMD, WRITE_STATUS_CMD, 8'h3C};
    send(0);
    check("joint write_status_cmd", status_byte, 8'h30);
    q = '{WRITE_ENABLE_CMD};
    send(0);
    check("wel set", status_byte, 8'h32);
    q = '{WRITE_DISABLE_CMD};
    send(0);
    check("wel clr", status_byte, 8'h30);
  endtask

  // Page wrap at the top of the array, then read wrap to zero
  task automatic t_page();
    d = '{8'hA1, 8'hB2, 8'hC3};
    wr_array(9'h1FF, 0);
    check("wip set", status_byte, 8'h33);
    // Disable while busy must be ignored, the latch stays set
    q = '{WRITE_DISABLE_CMD};
    send(0);
    check("busy write_disable_cmd", status_byte, 8'h33);
    wire_status(8'h33);
    wait_idle();
    check("wr done", status_byte, 8'h30);
    d = '{8'h5A};
    wr_array(9'h000, 0);
    wait_idle();
    d = '{8'hB2, 8'hC3};
    rd_check(9'h1F0);
    d = '{8'hA1, 8'h5A};
    rd_check(9'h1FF);
  endtask

  // Broken last byte and unframed enable must leave the array alone
  task automatic t_abort();
    d = '{8'h11};
    wr_array(9'h1F0, 3);
    repeat (10) @(posedge clk_sys);
    check("abort", status_byte, 8'h32);
    q = '{WRITE_DISABLE_CMD};
    send(0);
    q = '{WRITE_ENABLE_CMD, op(WRITE_ARRAY_CMD, 1'b1), 8'hF1, 8'h22};
    send(0);
    check("joint wr", status_byte, 8'h30);
    d = '{8'hB2, 8'hC3};
    rd_check(9'h1F0);
  endtask

  task automatic t_protect();
    q = '{WRITE_ENABLE_CMD};
    send(0);
    wp_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    check("wp clr", status_byte, 8'h30);
    d = '{8'h77};
    wr_array(9'h1F0, 0);
    repeat (10) @(posedge clk_sys);
    check("wp wr", status_byte, 8'h30);
    wp_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    d = '{8'hB2};
    rd_check(9'h1F0);
  endtask

  // Lock the top quarter; top bits, latch bit and busy bit are not writable
  task automatic t_lock();
    q = '{WRITE_ENABLE_CMD};
    send(0);
    q = '{WRITE_STATUS_CMD, 8'hC7};
    send(0);
    wait_idle();
    check("write_status_cmd", status_byte, 8'h04);
    d = '{8'h99};
    wr_array(9'h180, 0);
    repeat (10) @(posedge clk_sys);
    check("locked", status_byte, 8'h06);
    wr_array(9'h17F, 0);
    check("unlocked", status_byte, 8'h07);
    wait_idle();
    check("idle", status_byte, 8'h04);
    rd_check(9'h17F);
  endtask

  // Main sequence
  initial begin
    fail_count = 0;
    n_tests    = 0;
    rst        = 1'b1;
    wp_n       = 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_latch();
    t_page();
    t_abort();
    t_protect();
    t_lock();
    stop_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #200us;
    fail_count++;
    stop_test();
  end
endmodule
